/* src/asr_host.sv */
// Host controller driving an asynchronous 8k x 8 static memory.
// One request at a time: a read or a write of one byte, or a
// retention hold that keeps the memory deselected.
// Assumes the memory pins connect directly; data bus tristate resolved
// outside from MEM_DQ_OE_N_OUT (low = host drives).
`timescale 1ns/1ns
module asr_host (
  // Clock and reset
  input  wire logic              SYS_CLK_IN,
  input  wire logic              SYS_RST_IN,
  input  wire logic              CLK_EN_IN,
  // User request
  input  wire logic              REQ_VALID_IN,
  input  wire asr_pkg::asr_req_s REQ_IN,
  output logic                   REQ_READY_OUT,
  output logic                   RD_VALID_OUT,
  output logic [7:0]             RD_DATA_OUT,
  // Retention control
  input  wire logic              RETAIN_IN,
  output logic                   RETAIN_ACK_OUT,
  // Memory pins
  output logic [12:0]            MEM_ADDR_OUT,
  output asr_pkg::asr_ctl_s      MEM_CTL_OUT,
  input  wire logic [7:0]        MEM_DQ_IN,
  output logic [7:0]             MEM_DQ_OUT,
  output logic                   MEM_DQ_OE_N_OUT
);
  import asr_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  asr_state_e        state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  asr_ctl_s          ctl_q, ctl_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d;
  logic              dq_oe_n_q, dq_oe_n_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic              rvld_q, rvld_d;
  logic              rdy_q, rdy_d;
  logic              ret_q, ret_d;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic              ret_s1_q, ret_s2_q;

  // Count reached a target cycle number
  function automatic logic cnt_at(input logic [CNT_W-1:0] c,
                                  input int n);
    return c >= CNT_W'(n - 1);
  endfunction

  // ****************************************************************
  // Timing budget at a 50 ns clock
  // ****************************************************************
  // Read: selects and output enable go out on the take edge and stay
  // for six cycles. The pins are sampled four edges in, 200 ns after
  // the address, which clears the slow access time with margin; the
  // two synchroniser flops then carry the byte to the release edge.
  // Sampling right at the access time would race the pin settling.
  // Write: the strobe stays low two cycles, 100 ns, which covers the
  // pulse width and the address setup to the end of the write.
  // The host keeps driving data one cycle past the strobe, so data
  // hold and address recovery need no extra state.
  // Limitation: a faster clock shrinks these margins; the counts are
  // rounded from the package times, not from the clock at run time.

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire take_req = rdy_q && REQ_VALID_IN;
  wire rd_done  = cnt_at(cnt_q, RD_WAIT_CYC + RD_SYNC_CYC);
  wire wr_done  = cnt_at(cnt_q, WR_LOW_CYC);
  wire flt_done = cnt_at(cnt_q, FLOAT_CYC);
  wire rec_done = cnt_at(cnt_q, REC_CYC);
  wire ret_done = cnt_at(cnt_q, RET_CYC);
  // Counter saturates so a long hold cannot wrap into a false done
  wire cnt_inc  = ~(&cnt_q);

  // Next state and pins
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_inc ? cnt_q + CNT_W'(1) : cnt_q;
    ctl_d     = ctl_q;
    addr_d    = addr_q;
    wdat_d    = wdat_q;
    dq_oe_n_d = dq_oe_n_q;
    rdat_d    = rdat_q;
    rvld_d    = 1'b0;
    rdy_d     = rdy_q;
    ret_d     = ret_q;
    case (state_q)
      ST_IDLE: begin
        if (ret_s2_q) begin
          ctl_d   = CTL_IDLE;
          rdy_d   = 1'b0;
          ret_d   = 1'b1;
          state_d = ST_HOLD;
          cnt_d   = CNT_RST;
        end else if (take_req) begin
          addr_d  = REQ_IN.addr;
          wdat_d  = REQ_IN.wdata;
          rdy_d   = 1'b0;
          cnt_d   = CNT_RST;
          ctl_d.sel_n = 1'b0;
          ctl_d.sel   = 1'b1;
          if (REQ_IN.wr) begin
            ctl_d.we_n = 1'b0;
            ctl_d.oe_n = 1'b1;
            dq_oe_n_d  = 1'b0;
            state_d    = ST_WRITE;
          end else begin
            ctl_d.oe_n = 1'b0;
            dq_oe_n_d  = 1'b1;
            state_d    = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (rd_done) begin
          rdat_d  = dq_s2_q;
          rvld_d  = 1'b1;
          ctl_d   = CTL_IDLE;
          state_d = ST_REC;
          cnt_d   = CNT_RST;
        end
      end
      ST_WRITE: begin
        if (wr_done) begin
          ctl_d   = CTL_IDLE;
          state_d = ST_REC;
          cnt_d   = CNT_RST;
        end
      end
      ST_REC: begin
        dq_oe_n_d = 1'b1;
        if (rec_done && flt_done) begin
          rdy_d   = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (ret_s2_q) begin
          cnt_d = CNT_RST;
        end else if (ret_done) begin
          ret_d   = 1'b0;
          rdy_d   = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d   = ST_IDLE;
        ctl_d     = CTL_IDLE;
        dq_oe_n_d = 1'b1;
        rdy_d     = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Input synchronisers; read data sampled two flops late, which the
  // extra read wait covers
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      dq_s1_q  <= 8'h00;
      dq_s2_q  <= 8'h00;
      ret_s1_q <= 1'b0;
      ret_s2_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      dq_s1_q  <= MEM_DQ_IN;
      dq_s2_q  <= dq_s1_q;
      ret_s1_q <= RETAIN_IN;
      ret_s2_q <= ret_s1_q;
    end
  end

  // Control state; clock enable low freezes every register
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_q   <= ST_IDLE;
      cnt_q     <= CNT_RST;
      ctl_q     <= CTL_IDLE;
      addr_q    <= 13'h0000;
      wdat_q    <= 8'h00;
      dq_oe_n_q <= 1'b1;
      rdat_q    <= 8'h00;
      rvld_q    <= 1'b0;
      rdy_q     <= 1'b1;
      ret_q     <= 1'b0;
    end else if (CLK_EN_IN) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      ctl_q     <= ctl_d;
      addr_q    <= addr_d;
      wdat_q    <= wdat_d;
      dq_oe_n_q <= dq_oe_n_d;
      rdat_q    <= rdat_d;
      rvld_q    <= rvld_d;
      rdy_q     <= rdy_d;
      ret_q     <= ret_d;
    end
  end

  // Outputs straight from flops; shared bus
  assign REQ_READY_OUT   = rdy_q;
  assign RD_VALID_OUT    = rvld_q;
  assign RD_DATA_OUT     = rdat_q;
  assign RETAIN_ACK_OUT  = ret_q;
  assign MEM_ADDR_OUT    = addr_q;
  assign MEM_CTL_OUT     = ctl_q;
  assign MEM_DQ_OUT      = wdat_q;
  assign MEM_DQ_OE_N_OUT = dq_oe_n_q;
endmodule

/* src/asr_pkg.sv */
// Constants and types for the host-side static memory controller.
// Assumes a 20 MHz system clock and an asynchronous 8k x 8 memory outside.
//
// Functional notes
// - Read cycle at least 120/150 ns
// - Write strobe low at least 70/90 ns
// - Address stable 85/100 ns before write end
// - Data valid 40/50 ns before write end
// - Address held 5 ns after write
// - Write ends at first strobe released
// - Host never drives bus during read
// - Deselect in retention, wait cycle after
package asr_pkg;

  // ****************************************************************
  // Widths and clock
  // ****************************************************************
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;

  // ****************************************************************
  // Slow grade timing in ns (covers the fast grade too)
  // ****************************************************************
  localparam int CYCLE_TIME_MIN_NS            = 150;
  localparam int ADDRESS_TO_DATA_DELAY_NS     = 150;
  localparam int OE_TO_DATA_DELAY_NS          = 60;
  localparam int OE_OFF_TO_FLOAT_DELAY_NS     = 50;
  localparam int WRITE_TO_FLOAT_DELAY_NS      = 50;
  localparam int WRITE_PULSE_MIN_NS           = 90;
  localparam int ADDRESS_BEFORE_WRITE_END_NS  = 100;
  localparam int DATA_BEFORE_WRITE_END_NS     = 50;
  localparam int WRITE_RECOVERY_MIN_NS        = 5;
  localparam int RETENTION_RECOVERY_TIME_NS   = CYCLE_TIME_MIN_NS;

  // ****************************************************************
  // Cycle counts, least times rounded up
  // ****************************************************************
  localparam int RD_WAIT_CYC = (ADDRESS_TO_DATA_DELAY_NS
                               + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Two synchroniser flops plus one cycle of settling margin
  localparam int RD_SYNC_CYC = 3;
  localparam int WR_LOW_CYC_A = (WRITE_PULSE_MIN_NS
                                + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_LOW_CYC_B = (ADDRESS_BEFORE_WRITE_END_NS
                                + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_LOW_CYC = (WR_LOW_CYC_A > WR_LOW_CYC_B) ?
                              WR_LOW_CYC_A : WR_LOW_CYC_B;
  localparam int FLOAT_CYC = (OE_OFF_TO_FLOAT_DELAY_NS
                             + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (WRITE_RECOVERY_MIN_NS
                           + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RET_CYC = (RETENTION_RECOVERY_TIME_NS
                           + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_REC   = 3'b011,
    ST_HOLD  = 3'b100
  } asr_state_e;

  // Request from the user side
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_s;

  // Memory control pins, selects and strobes
  typedef struct packed {
    logic sel_n;
    logic sel;
    logic oe_n;
    logic we_n;
  } asr_ctl_s;

  localparam asr_ctl_s CTL_IDLE = '{sel_n: 1'b1, sel: 1'b0,
                                   oe_n: 1'b1, we_n: 1'b1};
endpackage

/* verification/asr_mem_model.sv */
// Behavioural model of the 8k x 8 asynchronous static memory.
// Assumes host data and enable; resolves the shared bus itself.
`timescale 1ns/1ns
module asr_mem_model
  import asr_pkg::*;
#(
  parameter int DLY = 150
) (
  input  wire logic [12:0] addr,
  input  wire asr_ctl_s    ctl,
  input  wire logic [7:0]  dq_host,
  input  wire logic        dq_oe_n,
  output logic [7:0]       dq
);
  logic [7:0] mem [0:8191];
  logic [7:0] last;
  wire rd_on = !ctl.sel_n && ctl.sel && !ctl.oe_n && ctl.we_n;
  wire wr_on = !ctl.sel_n && ctl.sel && !ctl.we_n;
  wire [7:0] arr = mem[addr];
  wire [7:0] rd_late;
  wire       rd_on_d;
  // slow answer covers enable delay too
  // old data kept until the delayed copy moves
  assign #DLY rd_late = arr;
  assign #DLY rd_on_d = rd_on;
  // Released bus shows inverse of last level
  always @* if (!dq_oe_n) last = dq_host;
    else if (rd_on && rd_on_d) last = rd_late;
  assign dq = !dq_oe_n ? dq_host : (rd_on && rd_on_d) ? rd_late : ~last;
  always @(negedge wr_on) mem[addr] <= dq;
endmodule

/* verification/asr_props.sv */
// Pin-level checker for the host memory controller.
// Sees only asr_host ports; bound from the bench top file.
`timescale 1ns/1ns
module asr_props
  import asr_pkg::*;
(
  // Clock, reset, retention and read valid
  input wire logic       SYS_CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       RETAIN_IN,
  input wire logic       RETAIN_ACK_OUT,
  input wire logic       RD_VALID_OUT,
  // Memory pins
  input wire logic [12:0] MEM_ADDR_OUT,
  input wire asr_ctl_s   MEM_CTL_OUT,
  input wire logic [7:0] MEM_DQ_OUT,
  input wire logic       MEM_DQ_OE_N_OUT
);
  // ****
  // Properties, all in the one clock domain
  // ****
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_read_len: assert property ($fell(MEM_CTL_OUT.oe_n) |->
    (!MEM_CTL_OUT.oe_n && !MEM_CTL_OUT.sel_n && MEM_CTL_OUT.sel)[*6]
    ##1 MEM_CTL_OUT.oe_n) else $error("read cycle too short");
  a_rd_answer: assert property ($fell(MEM_CTL_OUT.oe_n) |->
    ##6 RD_VALID_OUT) else $error("read data late");
  a_wr_pulse: assert property ($fell(MEM_CTL_OUT.we_n) |->
    !MEM_CTL_OUT.we_n[*2] ##1 MEM_CTL_OUT.we_n) else $error("bad pulse");
  a_wr_addr: assert property ($fell(MEM_CTL_OUT.we_n) |=>
    $stable(MEM_ADDR_OUT)[*3]) else $error("write address moved");
  a_wr_data: assert property ($fell(MEM_CTL_OUT.we_n) |=>
    (!MEM_DQ_OE_N_OUT && $stable(MEM_DQ_OUT))[*2])
    else $error("write data not held");
  a_wr_bound: assert property (!MEM_CTL_OUT.we_n |->
    !MEM_CTL_OUT.sel_n && MEM_CTL_OUT.sel && MEM_CTL_OUT.oe_n)
    else $error("strobe outside select");
  a_no_clash: assert property (!MEM_CTL_OUT.oe_n |->
    MEM_DQ_OE_N_OUT) else $error("host drives during read");
  a_ret_idle: assert property (RETAIN_ACK_OUT |->
    MEM_CTL_OUT == CTL_IDLE) else $error("selected in retention");
  a_ret_wait: assert property ($fell(RETAIN_ACK_OUT) |->
    !$past(RETAIN_IN, 3)) else $error("recovery too short");
endmodule

/* verification/async_static_ram_8kx8_bench.sv */
// Self-checking bench for asr_host against the memory model.
// Assumes a 20 MHz clock; read results scored through a queue.
`timescale 1ns/1ns
module async_static_ram_8kx8_bench;
  import asr_pkg::*;
  logic       clk = 0, rst = 1, valid = 0, retain = 0;
  logic       ready, rdv, ack, dq_oe_n;
  logic [7:0] rdata, dq_o, dq, rd, shadow [0:8191], expq [$];
  logic [12:0] addr, ra;
  asr_req_s   req = '0;
  asr_ctl_s   ctl;
  int         fail_count = 0, check_count = 0, seed = 32'h5ae5, n;
  localparam logic [12:0] ADR [4] = '{13'h0000, 13'h1FFF, 13'h0FFF,
                                      13'h1000};
  initial forever #25 clk = ~clk;
  asr_host u_asr_host (.SYS_CLK_IN(clk), .SYS_RST_IN(rst),
    .CLK_EN_IN(1'b1), .REQ_VALID_IN(valid), .REQ_IN(req),
    .REQ_READY_OUT(ready), .RD_VALID_OUT(rdv), .RD_DATA_OUT(rdata),
    .RETAIN_IN(retain), .RETAIN_ACK_OUT(ack), .MEM_ADDR_OUT(addr),
    .MEM_CTL_OUT(ctl), .MEM_DQ_IN(dq), .MEM_DQ_OUT(dq_o),
    .MEM_DQ_OE_N_OUT(dq_oe_n));
  asr_mem_model #(.DLY(150)) u_asr_mem_model (.addr(addr), .ctl(ctl),
    .dq_host(dq_o), .dq_oe_n(dq_oe_n), .dq(dq));
  // ****
  // Tasks
  // ****
  task check(input logic [21:0] s, input logic [21:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hold request until taken, then drop it for one edge
  task xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
    req <= '{wr: w, addr: a, wdata: d};
    valid <= 1'b1;
    if (w) shadow[a] = d;
    else expq.push_back(shadow[a]);
    n = 0;
    do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 40);
    if (ready !== 1'b1) begin fail_count++; stop_test; end
    valid <= 1'b0;
    @(posedge clk);
  endtask
  task wait_ack(input logic lvl);
    n = 0;
    while (ack !== lvl && n < 40) begin @(posedge clk); n++; end
    if (ack !== lvl) begin fail_count++; stop_test; end
  endtask
  task edge_reads;
    for (int i = 0; i < 4; i++) xfer(1'b0, ADR[i], 8'h00);
  endtask
  // Scoreboard takes the oldest note per read pulse
  always @(posedge clk) if (rdv === 1'b1) begin
    if (expq.size() == 0) check(1, 0);
    else check(rdata, expq.pop_front());
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) xfer(1'b1, ADR[i], 8'hA5 ^ 8'(i * 17));
    edge_reads();
    $display("test edges done");
    // Random write then immediate read back
    for (int i = 0; i < 16; i++) begin
      ra = 13'($random(seed));
      rd = 8'($random(seed));
      xfer(1'b1, ra, rd);
      xfer(1'b0, ra, 8'h00);
    end
    $display("test random done");
    // retention: not ready, deselected, then data kept
    retain <= 1'b1;
    wait_ack(1'b1);
    check(ready, 0);
    check(ctl, CTL_IDLE);
    repeat (10) @(posedge clk);
    retain <= 1'b0;
    wait_ack(1'b0);
    edge_reads();
    $display("test retention done");
    n = 0;
    while (expq.size() > 0 && n < 40) begin @(posedge clk); n++; end
    if (expq.size() > 0) fail_count++;
    stop_test();
  end
endmodule

bind asr_host asr_props u_asr_props (.SYS_CLK_IN(SYS_CLK_IN),
  .SYS_RST_IN(SYS_RST_IN), .RETAIN_IN(RETAIN_IN),
  .RETAIN_ACK_OUT(RETAIN_ACK_OUT), .RD_VALID_OUT(RD_VALID_OUT),
  .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_CTL_OUT(MEM_CTL_OUT),
  .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE_N_OUT(MEM_DQ_OE_N_OUT));
